/* File: logic/uml_pkg.sv */
//==========================================================================
//==========================================================================
package uml_pkg;

    //======================================================================
    // Register map, byte addresses on the AXI4-Lite port.
    localparam int          UML_ADDR_W     = 8;
    localparam logic [7:0]  UML_OFS_TX_PTR = 8'h00;
    localparam logic [7:0]  UML_OFS_TX_CNT = 8'h04;
    localparam logic [7:0]  UML_OFS_CTRL   = 8'h08;
    localparam logic [7:0]  UML_OFS_STAT   = 8'h0C;
    localparam logic [7:0]  UML_OFS_INT    = 8'h10;
    localparam logic [7:0]  UML_OFS_MASK   = 8'h14;

    //======================================================================
    // Modem line control fields.
    localparam int          UML_CTRL_W     = 6;
    localparam int          UML_CTRL_DTR   = 0;
    localparam int          UML_CTRL_RTS   = 1;
    localparam int          UML_CTRL_AUX_OUTPUT_ONE  = 2;
    localparam int          UML_CTRL_AUX_OUTPUT_TWO  = 3;
    localparam int          UML_CTRL_LOOP  = 4;
    localparam int          UML_CTRL_FCM   = 5;
    localparam logic [5:0]  UML_CTRL_RST   = 6'h00;

    //======================================================================
    // Modem line status fields; line order is cts, dsr, ring, carrier.
    localparam int          UML_LINES      = 4;
    localparam int          UML_ST_CHG     = 0;
    localparam int          UML_ST_LVL     = 4;
    localparam int          UML_ST_FLOW_CONTROL_READBACK    = 8;
    localparam int          UML_LN_CTS     = 0;
    localparam int          UML_LN_DSR     = 1;
    localparam int          UML_LN_RING    = 2;
    localparam int          UML_LN_DCD     = 3;
    localparam logic [3:0]  UML_PIN_IDLE   = 4'hF;

    //======================================================================
    // Interrupt status and mask fields, reset values of the datapath.
    localparam int          UML_INT_W      = 2;
    localparam int          UML_INT_MODEM  = 0;
    localparam int          UML_INT_TXDONE = 1;
    localparam logic [1:0]  UML_INT_RST    = 2'h0;
    localparam int          UML_CNT_W      = 16;
    localparam logic [15:0] UML_CNT_RST    = 16'h0000;
    localparam logic [31:0] UML_PTR_RST    = 32'h0000_0000;

    //======================================================================
    // Bus responses and transfer states.
    localparam logic [1:0]  UML_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  UML_RESP_SLV   = 2'h2;

    typedef enum {UML_TX_IDLE, UML_TX_REQ} uml_tx_state_t;

endpackage : uml_pkg

/* File: logic/uml_top.sv */
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module uml_top
    import uml_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [UML_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [UML_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  clear_send_pin_n,
    input  wire logic                  set_ready_pin_n,
    input  wire logic                  ring_pin_n,
    input  wire logic                  carrier_pin_n,
    output logic                       terminal_ready_pin_n,
    output logic                       request_send_pin_n,
    input  wire logic                  transmitter_ready_flag,
    input  wire logic                  tx_ack,
    output logic                       tx_req,
    output logic [31:0]                tx_buffer_address,
    output logic                       tx_enable,
    output logic                       modem_int,
    output logic                       irq
);

    //======================================================================
    // Register state.
    logic [31:0]          tx_buffer_pointer;
    logic [UML_CNT_W-1:0] tx_transfer_length;
    logic [5:0]           modem_line_control_reg;
    logic [3:0]           chg_flags;
    logic [1:0]           int_status;
    logic [1:0]           int_mask;
    uml_tx_state_t        tx_state;

    //======================================================================
    // Write channel holding registers.
    logic                  aw_have;
    logic                  w_have;
    logic [UML_ADDR_W-1:0] aw_addr_q;
    logic [31:0]           w_data_q;
    logic [3:0]            w_strb_q;
    logic                  wr_fire;
    logic                  next_aw_have;
    logic                  next_w_have;
    logic                  next_bvalid;
    logic                  next_rvalid;
    logic                  ar_fire;
    logic [31:0]           wr_mask;
    logic [31:0]           rd_word;
    logic                  rd_hit;

    function automatic logic [31:0] uml_lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[8*i +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction : uml_lane_mask

    // Address and data are taken in either order; the response waits
    // for both, and only one write is in flight at a time.
    assign wr_fire      = aw_have && w_have && !s_axi_bvalid;
    assign next_aw_have = (aw_have && !wr_fire)
                          || (s_axi_awvalid && s_axi_awready);
    assign next_w_have  = (w_have && !wr_fire)
                          || (s_axi_wvalid && s_axi_wready);
    assign next_bvalid  = wr_fire || (s_axi_bvalid && !s_axi_bready);
    assign wr_mask      = uml_lane_mask(w_strb_q);

    // Write address and data capture.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_addr_q     <= '0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_have       <= next_aw_have;
            w_have        <= next_w_have;
            s_axi_awready <= !next_aw_have && !next_bvalid;
            s_axi_wready  <= !next_w_have && !next_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= UML_RESP_OKAY;
        end else begin
            s_axi_bvalid <= next_bvalid;
            if (wr_fire) begin
                case (aw_addr_q)
                    UML_OFS_TX_PTR, UML_OFS_TX_CNT, UML_OFS_CTRL,
                    UML_OFS_STAT, UML_OFS_INT, UML_OFS_MASK: begin
                        s_axi_bresp <= UML_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= UML_RESP_SLV;
                    end
                endcase
            end
        end
    end

    //======================================================================
    // Modem input synchronisers and filter.
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_lvl_n;
    logic [3:0] agree;
    logic [3:0] line_on;
    logic [3:0] line_on_q;
    logic [3:0] line_evt;
    logic [3:0] next_chg;
    logic       stat_rd;

    // A level counts only once stages two and three agree, so a pin
    // that bounces across a sample edge cannot raise a flag twice.
    assign agree = pin_s2 ~^ pin_s3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1    <= UML_PIN_IDLE;
            pin_s2    <= UML_PIN_IDLE;
            pin_s3    <= UML_PIN_IDLE;
            pin_lvl_n <= UML_PIN_IDLE;
        end else begin
            pin_s1    <= {carrier_pin_n, ring_pin_n,
                          set_ready_pin_n, clear_send_pin_n};
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_lvl_n <= (agree & pin_s3) | (~agree & pin_lvl_n);
        end
    end

    // Asserted line levels; loop mode feeds the control bits back.
    always_comb begin
        if (modem_line_control_reg[UML_CTRL_LOOP]) begin
            line_on = {modem_line_control_reg[UML_CTRL_AUX_OUTPUT_TWO],
                       modem_line_control_reg[UML_CTRL_AUX_OUTPUT_ONE],
                       modem_line_control_reg[UML_CTRL_DTR],
                       modem_line_control_reg[UML_CTRL_RTS]};
        end else begin
            line_on = ~pin_lvl_n;
        end
    end

    // Ring is flagged only when the asserted level falls, which is the
    // pin going from low back to high at the end of a ring.
    assign line_evt[UML_LN_CTS]  = line_on[UML_LN_CTS]
                                   ^ line_on_q[UML_LN_CTS];
    assign line_evt[UML_LN_DSR]  = line_on[UML_LN_DSR]
                                   ^ line_on_q[UML_LN_DSR];
    assign line_evt[UML_LN_RING] = line_on_q[UML_LN_RING]
                                   & ~line_on[UML_LN_RING];
    assign line_evt[UML_LN_DCD]  = line_on[UML_LN_DCD]
                                   ^ line_on_q[UML_LN_DCD];

    // A change in the same cycle as the clearing read is kept.
    assign next_chg = (chg_flags & ~{UML_LINES{stat_rd}}) | line_evt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_on_q <= 4'h0;
            chg_flags <= 4'h0;
            modem_int <= 1'b0;
        end else begin
            line_on_q <= line_on;
            chg_flags <= next_chg;
            modem_int <= |next_chg;
        end
    end

    //======================================================================
    // Modem line control and its pins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modem_line_control_reg <= UML_CTRL_RST;
        end else if (wr_fire && aw_addr_q == UML_OFS_CTRL
                     && w_strb_q[0]) begin
            modem_line_control_reg <= w_data_q[UML_CTRL_W-1:0];
        end
    end

    // Pins are driven inverted so an external inverting driver gives
    // the usual line polarity.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            terminal_ready_pin_n <= 1'b1;
            request_send_pin_n   <= 1'b1;
            tx_enable            <= 1'b1;
        end else begin
            terminal_ready_pin_n <=
                !modem_line_control_reg[UML_CTRL_DTR];
            request_send_pin_n   <=
                !modem_line_control_reg[UML_CTRL_RTS];
            tx_enable <= !modem_line_control_reg[UML_CTRL_FCM]
                         || line_on[UML_LN_CTS];
        end
    end

    //======================================================================
    // Transmit transfer engine.
    logic                 ptr_wr;
    logic                 cnt_wr;
    logic                 cnt_wr_zero;
    logic                 tx_take;
    logic                 cts_ok;
    logic [31:0]          next_ptr_wr;
    logic [UML_CNT_W-1:0] next_cnt_wr;

    assign ptr_wr      = wr_fire && aw_addr_q == UML_OFS_TX_PTR;
    assign cnt_wr      = wr_fire && aw_addr_q == UML_OFS_TX_CNT;
    assign next_ptr_wr = (tx_buffer_pointer & ~wr_mask)
                         | (w_data_q & wr_mask);
    assign next_cnt_wr = (tx_transfer_length & wr_mask[UML_CNT_W-1:0])
                         ^ tx_transfer_length
                         | (w_data_q[UML_CNT_W-1:0]
                            & wr_mask[UML_CNT_W-1:0]);
    assign cnt_wr_zero = cnt_wr && next_cnt_wr == UML_CNT_RST;
    assign cts_ok      = !modem_line_control_reg[UML_CTRL_FCM]
                         || line_on[UML_LN_CTS];
    assign tx_take     = tx_req && tx_ack && !cnt_wr_zero;

    // Flow control is checked before each character is requested; a
    // request already made is allowed to complete.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state          <= UML_TX_IDLE;
            tx_req            <= 1'b0;
            tx_buffer_address <= UML_PTR_RST;
        end else begin
            case (tx_state)
                UML_TX_IDLE: begin
                    if (tx_transfer_length != UML_CNT_RST
                        && transmitter_ready_flag && cts_ok
                        && !cnt_wr) begin
                        tx_state          <= UML_TX_REQ;
                        tx_req            <= 1'b1;
                        tx_buffer_address <= tx_buffer_pointer;
                    end
                end
                UML_TX_REQ: begin
                    if (cnt_wr_zero || tx_ack) begin
                        tx_state <= UML_TX_IDLE;
                        tx_req   <= 1'b0;
                    end
                end
                default: begin
                    tx_state <= UML_TX_IDLE;
                    tx_req   <= 1'b0;
                end
            endcase
        end
    end

    // Software writes take priority over the automatic advance.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buffer_pointer  <= UML_PTR_RST;
            tx_transfer_length <= UML_CNT_RST;
        end else begin
            if (ptr_wr) begin
                tx_buffer_pointer <= next_ptr_wr;
            end else if (tx_take) begin
                tx_buffer_pointer <= tx_buffer_pointer + 32'h0000_0001;
            end
            if (cnt_wr) begin
                tx_transfer_length <= next_cnt_wr;
            end else if (tx_take) begin
                tx_transfer_length <= tx_transfer_length - 16'h0001;
            end
        end
    end

    //======================================================================
    // Interrupt status, write one to clear, and mask.
    logic [1:0] int_evt;
    logic [1:0] int_clr;
    logic [1:0] next_int;

    assign int_evt[UML_INT_MODEM]  = |line_evt;
    assign int_evt[UML_INT_TXDONE] = tx_take && !cnt_wr
                                     && tx_transfer_length == 16'h0001;
    assign int_clr  = (wr_fire && aw_addr_q == UML_OFS_INT && w_strb_q[0])
                      ? w_data_q[UML_INT_W-1:0] : 2'h0;
    assign next_int = (int_status & ~int_clr) | int_evt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= UML_INT_RST;
            int_mask   <= UML_INT_RST;
            irq        <= 1'b0;
        end else begin
            int_status <= next_int;
            if (wr_fire && aw_addr_q == UML_OFS_MASK && w_strb_q[0]) begin
                int_mask <= w_data_q[UML_INT_W-1:0];
            end
            irq <= |(next_int & int_mask);
        end
    end

    //======================================================================
    // Read channel; reading the status register clears the flags.
    assign ar_fire     = s_axi_arvalid && s_axi_arready;
    assign next_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
    assign stat_rd     = ar_fire && s_axi_araddr == UML_OFS_STAT;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            UML_OFS_TX_PTR: rd_word = tx_buffer_pointer;
            UML_OFS_TX_CNT: rd_word[UML_CNT_W-1:0] = tx_transfer_length;
            UML_OFS_CTRL:   rd_word[UML_CTRL_W-1:0] = modem_line_control_reg;
            UML_OFS_STAT: begin
                rd_word[UML_ST_CHG +: UML_LINES] = chg_flags;
                rd_word[UML_ST_LVL +: UML_LINES] = line_on;
                rd_word[UML_ST_FLOW_CONTROL_READBACK] =
                    modem_line_control_reg[UML_CTRL_FCM];
            end
            UML_OFS_INT:    rd_word[UML_INT_W-1:0] = int_status;
            UML_OFS_MASK:   rd_word[UML_INT_W-1:0] = int_mask;
            default:        rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= UML_RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_fire) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? UML_RESP_OKAY : UML_RESP_SLV;
            end
        end
    end

    //======================================================================
    // Assertions.
    sequence s_char_taken;
        tx_req && tx_ack && !cnt_wr_zero && !ptr_wr && !cnt_wr;
    endsequence

    a_dtr_pin_inverted: assert property (@(posedge aclk)
        disable iff (!aresetn) ##1 terminal_ready_pin_n ==
        !$past(modem_line_control_reg[UML_CTRL_DTR]))
        else $error("terminal ready pin not inverted control bit");
    a_rts_pin_inverted: assert property (@(posedge aclk)
        disable iff (!aresetn) ##1 request_send_pin_n ==
        !$past(modem_line_control_reg[UML_CTRL_RTS]))
        else $error("request send pin not inverted control bit");
    a_fcm_reset_low: assert property (@(posedge aclk)
        $past(!aresetn) |-> !modem_line_control_reg[UML_CTRL_FCM])
        else $error("flow control enable set after reset");
    a_flow_control_readback_readback: assert property (@(posedge aclk)
        disable iff (!aresetn) stat_rd |=>
        s_axi_rdata[UML_ST_FLOW_CONTROL_READBACK] ==
        $past(modem_line_control_reg[UML_CTRL_FCM]))
        else $error("flow control readback wrong");
    a_change_flag_set: assert property (@(posedge aclk)
        disable iff (!aresetn) line_evt[UML_LN_CTS] |=>
        chg_flags[UML_LN_CTS] ##1 1'b1)
        else $error("cts change not flagged");
    a_read_clears_flags: assert property (@(posedge aclk)
        disable iff (!aresetn) (stat_rd && line_evt == 4'h0) |=>
        chg_flags == 4'h0)
        else $error("status read did not clear change flags");
    a_ring_trailing_edge: assert property (@(posedge aclk)
        disable iff (!aresetn) $rose(chg_flags[UML_LN_RING]) |->
        $past(line_on_q[UML_LN_RING] && !line_on[UML_LN_RING]))
        else $error("ring flag without trailing edge");
    a_modem_int_raise: assert property (@(posedge aclk)
        disable iff (!aresetn) (|chg_flags) |-> modem_int)
        else $error("modem interrupt low with a change flag set");
    a_start_needs_count: assert property (@(posedge aclk)
        disable iff (!aresetn) $rose(tx_req) |->
        $past(tx_transfer_length != UML_CNT_RST
              && transmitter_ready_flag))
        else $error("transfer started with zero count or not ready");
    a_flow_gate: assert property (@(posedge aclk)
        disable iff (!aresetn) $rose(tx_req) |-> $past(cts_ok))
        else $error("transfer started with clear send inactive");
    a_pointer_advance: assert property (@(posedge aclk)
        disable iff (!aresetn) s_char_taken |=>
        tx_buffer_pointer == $past(tx_buffer_pointer) + 32'h0000_0001
        && tx_transfer_length == $past(tx_transfer_length) - 16'h0001
        ##1 !tx_req || tx_state == UML_TX_REQ)
        else $error("pointer or count did not advance");
    a_loop_mirror: assert property (@(posedge aclk)
        disable iff (!aresetn) modem_line_control_reg[UML_CTRL_LOOP] |->
        line_on[UML_LN_CTS] ==
        modem_line_control_reg[UML_CTRL_RTS])
        else $error("loop mode cts does not follow rts");

endmodule : uml_top

/* File: dv/uml_modem_model.sv */
`timescale 1ns/1ps
//=============================================
// Far-side modem driving its four status lines.
module uml_modem_model #(
    parameter int LAG_NS = 37
) (
    input  wire logic [3:0] want,
    output logic            clear_send_pin_n,
    output logic            set_ready_pin_n,
    output logic            ring_pin_n,
    output logic            carrier_pin_n
);
    logic [3:0] ln = 4'hF;
    // Lines move off the clock grid, so the block must synchronise them.
    always @(want) ln <= #LAG_NS want;
    assign {carrier_pin_n, ring_pin_n} = ln[3:2];
    assign {set_ready_pin_n, clear_send_pin_n} = ln[1:0];
endmodule : uml_modem_model

/* File: dv/usart_modem_lines_tx_dma_test.sv */
`timescale 1ns/1ps
module usart_modem_lines_tx_dma_test
    import uml_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, tx_ack = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic transmitter_ready_flag = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, p;
    logic [3:0] s_axi_wstrb = 4'hF, want = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, terminal_ready_pin_n, request_send_pin_n, tx_req;
    logic tx_enable, modem_int, irq, clear_send_pin_n, set_ready_pin_n;
    logic ring_pin_n, carrier_pin_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, tx_buffer_address, eq[$], aq[$];
    logic [1:0] rq[$];
    logic [3:0] w_tab [4] = '{4'hE, 4'h4, 4'h0, 4'hF};
    logic [31:0] s_tab [4] = '{32'h11, 32'hBA, 32'hF0, 32'h0F};
    int num_errors = 0, n_tests = 0, n;

    uml_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clear_send_pin_n,
        .set_ready_pin_n, .ring_pin_n, .carrier_pin_n, .terminal_ready_pin_n,
        .request_send_pin_n, .transmitter_ready_flag, .tx_ack, .tx_req,
        .tx_buffer_address, .tx_enable, .modem_int, .irq);
    uml_modem_model modem (.want, .clear_send_pin_n, .set_ready_pin_n,
        .ring_pin_n, .carrier_pin_n);

    always #50 aclk = ~aclk;

    task automatic chk(input logic [31:0] g, e, input string nm);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up;
        if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic nap;
        repeat (12) @(posedge aclk);
    endtask : nap

    // Address and data go out together; each drops once it is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw = 0, w = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1;
            if (s_axi_wready) w = 1;
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        eq.push_back(e);
        // Offsets past the mask register are unmapped and answer an error.
        rq.push_back((a > UML_OFS_MASK) ? UML_RESP_SLV : UML_RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
    endtask : rd

    // Results are matched to the oldest note; the sink acks each char late.
    always @(posedge aclk) begin
        if (s_axi_rvalid) chk(s_axi_rdata, eq.pop_front(), "rdata");
        if (s_axi_rvalid) chk(s_axi_rresp, rq.pop_front(), "rresp");
        if (tx_req && tx_ack) chk(tx_buffer_address, aq.pop_front(), "ad");
        tx_ack <= tx_req & ~tx_ack;
    end

    initial begin
        #3_000_000;
        num_errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(82));
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rd(UML_OFS_CTRL, 0);
        rd(UML_OFS_STAT, 0);
        rd(8'h18, 0);
        for (int i = 1; i < 4; i++) begin
            wr(UML_OFS_CTRL, i);
            nap();
            chk({request_send_pin_n, terminal_ready_pin_n}, ~i & 3, "pn");
        end
        wr(UML_OFS_CTRL, 0);
        for (int i = 0; i < 4; i++) begin
            want <= w_tab[i];
            nap();
            chk(modem_int, |s_tab[i][3:0], "mint");
            rd(UML_OFS_STAT, s_tab[i]);
            rd(UML_OFS_STAT, s_tab[i] & 32'hF0);
        end
        for (int i = 0; i < 2; i++) begin
            wr(UML_OFS_CTRL, i ? 0 : 32'h1F);
            nap();
            rd(UML_OFS_STAT, i ? 32'h0F : 32'hFB);
        end
        wr(UML_OFS_MASK, 1);
        nap();
        chk(irq, 1, "irq");
        wr(UML_OFS_INT, 3);
        nap();
        chk(irq, 0, "irq");
        wr(UML_OFS_CTRL, 32'h20);
        rd(UML_OFS_STAT, 32'h100);
        chk(tx_enable, 0, "ten");
        p = $urandom;
        n = 2 + $urandom % 4;
        wr(UML_OFS_TX_PTR, p);
        wr(UML_OFS_TX_CNT, n);
        transmitter_ready_flag <= 1'h1;
        nap();
        chk(tx_req, 0, "req");
        for (int i = 0; i < n; i++) aq.push_back(p + i);
        want <= 4'hE;
        repeat (60) @(posedge aclk);
        chk(aq.size(), 0, "sent");
        chk(tx_enable, 1, "ten");
        rd(UML_OFS_TX_CNT, 0);
        rd(UML_OFS_TX_PTR, p + n);
        rd(UML_OFS_INT, 3);
        wrap_up();
    end
endmodule : usart_modem_lines_tx_dma_test
